// file: verilog/agdet_pkg.sv
// Shared constants and carrier types of the acquisition gate block.
// Assumes one clock domain; register indices sit on a plain port.
package agdet_pkg;
    // Register indices
    localparam logic [3:0] REG_CFG = 4'h0;
    localparam logic [3:0] REG_VALUE = 4'h1;
    localparam logic [3:0] REG_SWCFG = 4'h2;
    localparam logic [3:0] REG_UNITMAP = 4'h3;
    localparam logic [3:0] REG_PRESET = 4'h4;
    localparam logic [3:0] REG_CMD = 4'h5;
    localparam logic [3:0] REG_STATUS = 4'h6;
    localparam logic [3:0] REG_SWCOUNT = 4'h7;
    // Digital port configuration word
    localparam int CFG_W = 12;
    localparam int CFG_STATUS = 0;
    localparam int CFG_VALUE = 1;
    localparam int CFG_INVERT = 2;
    localparam int CFG_PUSHPULL = 3;
    localparam int CFG_TRIG_LSB = 4;
    localparam int CFG_GATE_WATCH = 8;
    localparam int CFG_GATE_RAISE = 9;
    localparam int CFG_GATE_DROP = 10;
    localparam int CFG_CLR_REARM = 11;
    // Sweep configuration word
    localparam int SWC_W = 8;
    localparam int SWC_PRESET_EN = 2;
    localparam int SWC_WRAP = 6;
    localparam int SWC_MARK = 7;
    // Command word
    localparam int CMD_START_LSB = 0;
    localparam int CMD_STOP_LSB = 4;
    localparam int CMD_ERASE_LSB = 8;
    // Unit map nibble: system, active, four-input
    localparam int UM_W = 4;
    localparam int UM_SYS_LSB = 0;
    localparam int UM_ACTIVE = 2;
    localparam int UM_FOUR = 3;
    localparam logic [UM_W-1:0] UM_RST = 4'h4;
    // Port and systems
    localparam int SYS_N = 4;
    localparam int DIO_W = 8;
    localparam int TRIG_PIN_LSB = 4;
    localparam logic [DIO_W-1:0] STATUS_MASK = 8'h0F;
    localparam logic [DIO_W-1:0] VALUE_MASK = 8'hFF;
    // Start marker words
    localparam logic [31:0] MARK_COARSE = 32'hC0000000;
    localparam logic [31:0] MARK_FINE = 32'h80000000;

    typedef struct packed {
        logic [SYS_N-1:0] start;
        logic [SYS_N-1:0] stop;
        logic [SYS_N-1:0] erase;
    } agdet_cmd_t;

    typedef struct packed {
        logic valid;
        logic [1:0] chan;
        logic [30:0] stamp;
    } agdet_evin_t;

    typedef struct packed {
        logic valid;
        logic [31:0] word;
    } agdet_evw_t;
endpackage

// file: verilog/agdet_sys_ctrl.sv
// Run controller of one system: plain start, or armed start by trigger.
// Assumes trig_act is synchronised and already polarity corrected.
`timescale 1ns/100ps
module agdet_sys_ctrl
    import agdet_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic cmd_start,
    input wire logic cmd_stop,
    input wire logic preset_hit,
    input wire logic trig_en,
    input wire logic trig_act,
    input wire logic clr_on_arm,
    output logic running,
    output logic armed,
    output logic clear_pulse,
    output logic halt_pulse
);
    typedef enum logic [1:0] {SYS_IDLE, SYS_ARMED, SYS_CLEAR, SYS_RUN} agdet_sys_state_t;
    agdet_sys_state_t state, next_state;
    logic ext_mode, trig_prev, trig_fall, arm_clear;

    assign trig_fall = trig_act & ~trig_prev;

    // Next state; stop beats preset, preset beats trigger
    always_comb begin
        next_state = state;
        arm_clear = 1'b0;
        unique case (state)
            SYS_IDLE: begin
                if (cmd_start && !cmd_stop) begin
                    if (trig_en) begin
                        next_state = SYS_ARMED;
                        arm_clear = clr_on_arm;
                    end else begin
                        next_state = SYS_CLEAR;
                    end
                end
            end
            SYS_ARMED: begin
                if (cmd_stop) begin
                    next_state = SYS_IDLE;
                end else if (trig_fall) begin
                    next_state = SYS_CLEAR;
                end
            end
            SYS_CLEAR: begin
                next_state = cmd_stop ? SYS_IDLE : SYS_RUN;
            end
            SYS_RUN: begin
                if (cmd_stop || preset_hit) begin
                    next_state = SYS_IDLE;
                end else if (ext_mode && !trig_act) begin
                    next_state = SYS_ARMED;
                end
            end
        endcase
    end

    // State and registered outputs
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state <= SYS_IDLE;
            running <= 1'b0;
            armed <= 1'b0;
            clear_pulse <= 1'b0;
            halt_pulse <= 1'b0;
        end else begin
            state <= next_state;
            running <= next_state == SYS_RUN;
            armed <= next_state == SYS_ARMED;
            clear_pulse <= (next_state == SYS_CLEAR) | arm_clear;
            halt_pulse <= (state == SYS_RUN) && (next_state != SYS_RUN);
        end
    end

    // Trigger history and latched start kind
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            trig_prev <= 1'b0;
            ext_mode <= 1'b0;
        end else begin
            trig_prev <= trig_act;
            if (state == SYS_IDLE && cmd_start) begin
                ext_mode <= trig_en;
            end
        end
    end

    sequence s_trig_start;
        state == SYS_ARMED && !cmd_stop && trig_fall;
    endsequence

    trig_clear_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        s_trig_start |=> clear_pulse && !running ##1 (running || $past(cmd_stop)))
        else $error("triggered start did not clear then run");
    armed_wait_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        state == SYS_IDLE && cmd_start && trig_en && !cmd_stop |=> armed && !running [*2])
        else $error("armed start ran without trigger");
    stop_end_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        cmd_stop |=> !running && !armed)
        else $error("stop did not end monitoring");
    ext_halt_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        running && ext_mode && !trig_act && !cmd_stop && !preset_hit |=> armed && halt_pulse)
        else $error("trigger release did not halt and rearm");
endmodule

// file: verilog/agdet_top.sv
// Acquisition control: digital port, external triggers, gate line,
// system grouping of units and event word tagging with start markers.
// Assumes sweep and event strobes come from logic on clk_sys.
//
// Contract
// - Status mode: status pin high while the system runs, low otherwise.
// - Invert option flips status and value levels on the port.
// - Value mode drives the programmable 8-bit value on the port.
// - Value mode adds one to the port value at each acquisition stop.
// - Port drive selectable between push-pull and open-drain.
// - Digital inputs 4 to 7 serve as start triggers of systems 1 to 4.
// - With trigger enabled, start only arms and watches the trigger level.
// - Armed: high-to-low trigger edge clears data, then starts acquisition.
// - Trigger return stops acquisition, rearms; invert swaps polarity.
// - Stop command ends trigger monitoring of that system.
// - Up to four unit groups obey one start, stop or erase together.
// - Gate line gates acquisition: watch, raise at start, drop at preset.
// - Drop option pulls gate low at once when sweep preset is reached.
// - Each unit runs two-input fine or four-input coarse mode.
// - Fine mode: bit 31 alone names input one or two.
// - Coarse mode: bits 31 and 30 name inputs one to four.
// - Start marker is C0000000h coarse, 80000000h fine.
// - Wrap-around mode emits exactly one start marker per run.
// - Events between two markers belong to one sweep.
// - Port configuration word bits 0 to 11 hold the listed options.
// - Marker option inserts a marker word at each sweep start.
//
// The implementer's own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
module agdet_top
    import agdet_pkg::*;
#(
    parameter int N_UNITS = 4
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic [DIO_W-1:0] dio_in,
    output logic [DIO_W-1:0] dio_o,
    output logic [DIO_W-1:0] dio_oe,
    input wire logic gate_in,
    output logic gate_o,
    output logic gate_oe,
    input wire logic sweep_start,
    input wire logic sweep_done,
    input wire agdet_evin_t ev_in,
    output logic ev_ready,
    output agdet_evw_t ev_out,
    output logic [N_UNITS-1:0] unit_run,
    output logic [N_UNITS-1:0] unit_clear,
    output logic [N_UNITS-1:0] unit_four_input
);
    logic [CFG_W-1:0] cfg;
    logic [7:0] value;
    logic [SWC_W-1:0] swcfg;
    logic [N_UNITS*UM_W-1:0] unit_map;
    logic [31:0] preset;
    logic [31:0] sweep_cnt;
    agdet_cmd_t cmd;
    logic [DIO_W-1:0] dio_meta, dio_sync;
    logic gate_meta, gate_sync;
    logic [SYS_N-1:0] trig_en, trig_act, sys_hit;
    logic [SYS_N-1:0] sys_run, sys_armed, sys_clear, sys_halt;
    logic [1:0] sys_a;
    logic a_active, four_a, run_a, run_a_d, halt_a, preset_hit;
    logic step_value_on_halt, gate_raise_on_run, gate_drop_on_preset, gate_monitor_enable;
    logic gate_ok, accept, mark_fire, mark_sent, pend;
    logic [31:0] ev_word, mark_word, pend_word, next_rdata;
    logic [DIO_W-1:0] next_level, next_mask;

    // Field of one unit in the unit map
    function automatic logic [1:0] unit_sys(input logic [N_UNITS*UM_W-1:0] map, input int u);
        return map[u*UM_W+UM_SYS_LSB +: 2];
    endfunction

    function automatic logic unit_flag(input logic [N_UNITS*UM_W-1:0] map, input int u, input int b);
        return map[u*UM_W+b];
    endfunction

    // Option bits of the port configuration word
    assign step_value_on_halt = cfg[CFG_VALUE];
    assign gate_monitor_enable = cfg[CFG_GATE_WATCH];
    assign gate_raise_on_run = cfg[CFG_GATE_RAISE];
    assign gate_drop_on_preset = cfg[CFG_GATE_DROP];

    // Two-stage synchronisers for pins from outside
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            dio_meta <= '1; // Idle at the pull-up level, no false trigger edge
            dio_sync <= '1;
            gate_meta <= 1'b0;
            gate_sync <= 1'b0;
        end else begin
            dio_meta <= dio_in;
            dio_sync <= dio_meta;
            gate_meta <= gate_in;
            gate_sync <= gate_meta;
        end
    end

    // Command word decode, one-cycle pulses
    always_comb begin
        cmd = '0;
        if (reg_wr && reg_addr == REG_CMD) begin
            cmd.start = reg_wdata[CMD_START_LSB +: SYS_N];
            cmd.stop = reg_wdata[CMD_STOP_LSB +: SYS_N];
            cmd.erase = reg_wdata[CMD_ERASE_LSB +: SYS_N];
        end
    end

    // Register writes
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cfg <= '0;
            swcfg <= '0;
            preset <= '0;
            unit_map <= {{(N_UNITS*UM_W-UM_W){1'b0}}, UM_RST};
        end else if (reg_wr) begin
            if (reg_addr == REG_CFG) begin
                cfg <= reg_wdata[CFG_W-1:0];
            end
            if (reg_addr == REG_SWCFG) begin
                swcfg <= reg_wdata[SWC_W-1:0];
            end
            if (reg_addr == REG_PRESET) begin
                preset <= reg_wdata;
            end
            if (reg_addr == REG_UNITMAP) begin
                unit_map <= reg_wdata[N_UNITS*UM_W-1:0];
            end
        end
    end

    // Unit A drives preset, port value and event tagging
    assign sys_a = unit_sys(unit_map, 0);
    assign a_active = unit_flag(unit_map, 0, UM_ACTIVE);
    assign four_a = unit_flag(unit_map, 0, UM_FOUR);
    assign run_a = a_active & sys_run[sys_a];
    assign halt_a = a_active & sys_halt[sys_a];

    // One controller per system, each with its own trigger pin
    for (genvar s = 0; s < SYS_N; s++) begin : g_sys
        assign trig_en[s] = cfg[CFG_TRIG_LSB+s];
        assign trig_act[s] = cfg[CFG_INVERT] ? dio_sync[TRIG_PIN_LSB+s] : ~dio_sync[TRIG_PIN_LSB+s];
        assign sys_hit[s] = preset_hit && (sys_a == 2'(s));
        agdet_sys_ctrl u_ctrl (
            .clk_sys(clk_sys),
            .resetn(resetn),
            .cmd_start(cmd.start[s]),
            .cmd_stop(cmd.stop[s]),
            .preset_hit(sys_hit[s]),
            .trig_en(trig_en[s]),
            .trig_act(trig_act[s]),
            .clr_on_arm(cfg[CFG_CLR_REARM]),
            .running(sys_run[s]),
            .armed(sys_armed[s]),
            .clear_pulse(sys_clear[s]),
            .halt_pulse(sys_halt[s])
        );
    end

    // Units follow the system they are grouped into
    for (genvar u = 0; u < N_UNITS; u++) begin : g_unit
        always_ff @(posedge clk_sys or negedge resetn) begin
            if (!resetn) begin
                unit_run[u] <= 1'b0;
                unit_clear[u] <= 1'b0;
                unit_four_input[u] <= 1'b0;
            end else begin
                unit_run[u] <= unit_flag(unit_map, u, UM_ACTIVE) & sys_run[unit_sys(unit_map, u)];
                unit_clear[u] <= unit_flag(unit_map, u, UM_ACTIVE)
                    & (sys_clear[unit_sys(unit_map, u)] | cmd.erase[unit_sys(unit_map, u)]);
                unit_four_input[u] <= unit_flag(unit_map, u, UM_FOUR);
            end
        end
    end

    // Sweep preset: hit on the completion of the last counted sweep
    assign preset_hit = swcfg[SWC_PRESET_EN] && run_a && sweep_done && (preset != '0)
        && (sweep_cnt + 32'h00000001 == preset);

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            sweep_cnt <= '0;
        end else if (a_active && sys_clear[sys_a]) begin
            sweep_cnt <= '0;
        end else if (run_a && sweep_done) begin
            sweep_cnt <= sweep_cnt + 32'h00000001;
        end
    end

    // Port value; a write wins over the stop step
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            value <= '0;
        end else if (reg_wr && reg_addr == REG_VALUE) begin
            value <= reg_wdata[7:0];
        end else if (step_value_on_halt && halt_a) begin
            value <= value + 8'h01;
        end
    end

    // Port levels and drive mask; pins of enabled triggers are never driven
    always_comb begin
        next_level = '0;
        next_mask = '0;
        if (step_value_on_halt) begin
            next_level = value;
            next_mask = VALUE_MASK;
        end else if (cfg[CFG_STATUS]) begin
            next_level = {{(DIO_W-SYS_N){1'b0}}, sys_run};
            next_mask = STATUS_MASK;
        end
        next_level = next_level ^ {DIO_W{cfg[CFG_INVERT]}};
        next_mask = next_mask & ~{trig_en, {TRIG_PIN_LSB{1'b0}}};
    end

    // Push-pull drives both levels, open drain only pulls low
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            dio_o <= '0;
            dio_oe <= '0;
        end else if (cfg[CFG_PUSHPULL]) begin
            dio_o <= next_level;
            dio_oe <= next_mask;
        end else begin
            dio_o <= '0;
            dio_oe <= next_mask & ~next_level;
        end
    end

    // Gate line drive: raise at run start, pull low at preset, free at stop
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            run_a_d <= 1'b0;
            gate_o <= 1'b0;
            gate_oe <= 1'b0;
        end else begin
            run_a_d <= run_a;
            if (preset_hit && gate_drop_on_preset) begin
                gate_o <= 1'b0;
                gate_oe <= 1'b1;
            end else if (run_a && !run_a_d && gate_raise_on_run) begin
                gate_o <= 1'b1;
                gate_oe <= 1'b1;
            end else if (cmd.stop[sys_a]) begin
                gate_o <= 1'b0;
                gate_oe <= 1'b0;
            end
        end
    end

    // Event acceptance under the gate and tagging by unit mode
    assign gate_ok = !gate_monitor_enable || gate_sync;
    assign ev_ready = !pend;
    assign accept = ev_in.valid && !pend && run_a && gate_ok;
    assign ev_word = four_a ? {ev_in.chan[1], ev_in.chan[0], ev_in.stamp[29:0]}
        : {ev_in.chan[0], ev_in.stamp};
    assign mark_word = four_a ? MARK_COARSE : MARK_FINE;
    assign mark_fire = swcfg[SWC_MARK] && run_a && sweep_start
        && !(swcfg[SWC_WRAP] && mark_sent);

    // Marker history of the current run; a new marker wins over the clear
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            mark_sent <= 1'b0;
        end else if (mark_fire) begin
            mark_sent <= 1'b1;
        end else if (!run_a) begin
            mark_sent <= 1'b0;
        end
    end

    // Output stream; an event beside a marker is held one cycle behind it
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ev_out <= '0;
            pend <= 1'b0;
            pend_word <= '0;
        end else if (mark_fire) begin
            ev_out <= {1'b1, mark_word};
            pend <= accept;
            pend_word <= ev_word;
        end else if (pend) begin
            ev_out <= {1'b1, pend_word};
            pend <= 1'b0;
        end else begin
            ev_out <= {accept, ev_word};
        end
    end

    // Read mux, data stand only in the cycle after the strobe
    always_comb begin
        next_rdata = '0;
        unique case (reg_addr)
            REG_CFG: next_rdata[CFG_W-1:0] = cfg;
            REG_VALUE: next_rdata[7:0] = value;
            REG_SWCFG: next_rdata[SWC_W-1:0] = swcfg;
            REG_UNITMAP: next_rdata[N_UNITS*UM_W-1:0] = unit_map;
            REG_PRESET: next_rdata = preset;
            REG_STATUS: next_rdata[2*SYS_N-1:0] = {sys_armed, sys_run};
            REG_SWCOUNT: next_rdata = sweep_cnt;
            default: next_rdata = '0;
        endcase
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= '0;
        end else begin
            reg_rdata <= reg_rd ? next_rdata : '0;
        end
    end

    sequence s_status_mode;
        cfg[CFG_STATUS] && !cfg[CFG_VALUE] && cfg[CFG_PUSHPULL];
    endsequence

    status_pin_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        s_status_mode ##1 s_status_mode |-> dio_oe[0] && dio_o[0] == ($past(sys_run[0]) ^ $past(cfg[CFG_INVERT])))
        else $error("status pin does not follow run state");
    value_step_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        step_value_on_halt && halt_a && !(reg_wr && reg_addr == REG_VALUE) |=> value == $past(value) + 8'h01)
        else $error("port value not stepped at stop");
    open_drain_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        !cfg[CFG_PUSHPULL] ##1 !cfg[CFG_PUSHPULL] |-> (dio_o & dio_oe) == '0)
        else $error("open drain drives high");
    gate_drop_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        preset_hit && gate_drop_on_preset |=> gate_oe && !gate_o ##1 !run_a)
        else $error("gate not pulled low at preset");
    marker_word_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        mark_fire |=> ev_out.valid && ev_out.word == ($past(four_a) ? MARK_COARSE : MARK_FINE))
        else $error("wrong start marker word");
    wrap_once_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        mark_fire && swcfg[SWC_WRAP] ##1 (run_a && swcfg[SWC_WRAP]) |-> !mark_fire)
        else $error("second marker in wrap mode");
    gate_watch_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        ev_in.valid && gate_monitor_enable && !gate_sync && !mark_fire && !pend |=> !ev_out.valid)
        else $error("event taken while gate low");
    sync_delay_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        $past(resetn, 2) && $past(resetn) |-> gate_sync == $past(gate_in, 2))
        else $error("gate input not two stages late");
endmodule

// file: test/agdet_ext_model.sv
// Far-side equipment: trigger sources on port pins 4..7, pull-ups elsewhere.
// Assumes the bench steers trig_lvl; port pins 0..3 and gate line are pulled up.
`timescale 1ns/100ps
module agdet_ext_model
    import agdet_pkg::*;
(
    input wire logic [3:0] trig_lvl,
    input wire logic [DIO_W-1:0] dio_o,
    input wire logic [DIO_W-1:0] dio_oe,
    input wire logic gate_o,
    input wire logic gate_oe,
    output logic [DIO_W-1:0] dio_in,
    output logic gate_in
);
    // Released pins float to the pull-up level, trigger pins follow the equipment
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            dio_in[i] = dio_oe[i] ? dio_o[i] : 1'b1;
        end
        dio_in[7:4] = trig_lvl;
    end
    // Gate line pull-up
    assign gate_in = gate_oe ? gate_o : 1'b1;
endmodule

// file: test/tb_top.sv
// Self-checking bench of the acquisition gate block.
// Assumes the external equipment model drives port inputs and the gate line.
`timescale 1ns/100ps
module tb_top;
    import agdet_pkg::*;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic sweep_start = 1'b0;
    logic sweep_done = 1'b0;
    logic [3:0] trig_lvl = 4'hF;
    agdet_evin_t ev_in = '0;
    logic [31:0] reg_rdata;
    logic [DIO_W-1:0] dio_in, dio_o, dio_oe;
    logic gate_in, gate_o, gate_oe, ev_ready;
    agdet_evw_t ev_out;
    logic [3:0] unit_run, unit_clear, unit_four_input;
    logic [1:0] clr_seen = 2'h0;
    int n_errors = 0;
    int comparisons = 0;
    int cycles = 0;

    agdet_top #(.N_UNITS(4)) i_agdet_top (.clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dio_in(dio_in),
        .dio_o(dio_o), .dio_oe(dio_oe), .gate_in(gate_in), .gate_o(gate_o), .gate_oe(gate_oe),
        .sweep_start(sweep_start), .sweep_done(sweep_done), .ev_in(ev_in), .ev_ready(ev_ready),
        .ev_out(ev_out), .unit_run(unit_run), .unit_clear(unit_clear), .unit_four_input(unit_four_input));
    agdet_ext_model i_agdet_ext_model (.trig_lvl(trig_lvl), .dio_o(dio_o), .dio_oe(dio_oe),
        .gate_o(gate_o), .gate_oe(gate_oe), .dio_in(dio_in), .gate_in(gate_in));

    // Clock and hang guard
    initial begin
        forever #25 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        clr_seen <= clr_seen | unit_clear[1:0];
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            stop_test;
        end
    end

    task automatic stop_test;
        $display("errors=%0d comparisons=%0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 chk({1'b0, reg_rdata}, {1'b0, e});
    endtask
    // Sweep start with an event beside it; checks the next two output cycles
    task automatic sweep_ev(input logic [1:0] ch, input logic [32:0] e1, input logic [32:0] e2);
        @(posedge clk_sys);
        sweep_start <= 1'b1;
        ev_in <= '{1'b1, ch, 31'h15};
        @(posedge clk_sys);
        sweep_start <= 1'b0;
        ev_in.valid <= 1'b0;
        #1 chk(ev_out, e1);
        chk({32'h0, ev_ready}, {32'h0, e1[29:0] != 30'h0});
        tick(1);
        chk({ev_out.valid, ev_out.word & {32{e2[32]}}}, e2);
    endtask

    task automatic t_regs;
        rd(REG_UNITMAP, 32'h4);
        wr(REG_CFG, 32'hFFFFFFFF);
        rd(REG_CFG, 32'hFFF);
        wr(4'hF, 32'h1234);
        rd(4'hF, 32'h0);
        wr(REG_CFG, 32'h0);
    endtask
    task automatic t_status;
        wr(REG_UNITMAP, 32'h44);
        wr(REG_CFG, 32'h9);
        tick(2);
        chk({21'h0, dio_o[3:0], dio_oe}, 33'h00F);
        wr(REG_CMD, 32'h1);
        tick(4);
        chk({21'h0, dio_o[3:0], dio_oe}, 33'h10F);
        chk({31'h0, unit_run[1:0]}, 33'h3);
        wr(REG_CMD, 32'h10);
        tick(4);
        chk({21'h0, dio_o[3:0], dio_oe}, 33'h00F);
        clr_seen <= 2'h0;
        wr(REG_CMD, 32'h100);
        tick(3);
        chk({31'h0, clr_seen}, 33'h3);
        wr(REG_UNITMAP, 32'h4);
    endtask
    task automatic t_value;
        wr(REG_CFG, 32'hA);
        wr(REG_VALUE, 32'h7E);
        tick(2);
        chk({17'h0, dio_o, dio_oe}, 33'h7EFF);
        wr(REG_CMD, 32'h1);
        tick(4);
        wr(REG_CMD, 32'h10);
        tick(4);
        chk({17'h0, dio_o, dio_oe}, 33'h7FFF);
        wr(REG_CFG, 32'h6);
        tick(2);
        chk({17'h0, dio_o, dio_oe}, 33'h007F);
    endtask
    task automatic t_trig;
        wr(REG_CFG, 32'h10);
        wr(REG_CMD, 32'h1);
        tick(4);
        rd(REG_STATUS, 32'h10);
        clr_seen <= 2'h0;
        trig_lvl[0] <= 1'b0;
        tick(8);
        chk({32'h0, unit_run[0]}, 33'h1);
        chk({31'h0, clr_seen}, 33'h1);
        trig_lvl[0] <= 1'b1;
        tick(8);
        rd(REG_STATUS, 32'h10);
        wr(REG_CMD, 32'h10);
        tick(2);
        trig_lvl[0] <= 1'b0;
        tick(8);
        rd(REG_STATUS, 32'h0);
        trig_lvl[0] <= 1'b1;
        wr(REG_CFG, 32'h0);
    endtask
    task automatic t_events;
        wr(REG_SWCFG, 32'h80);
        wr(REG_CMD, 32'h1);
        tick(4);
        sweep_ev(2'd1, {1'b1, MARK_FINE}, 33'h1_8000_0015);
        wr(REG_CMD, 32'h10);
        wr(REG_UNITMAP, 32'hC);
        wr(REG_SWCFG, 32'hC0);
        wr(REG_CMD, 32'h1);
        tick(4);
        chk({32'h0, unit_four_input[0]}, 33'h1);
        sweep_ev(2'd3, {1'b1, MARK_COARSE}, 33'h1_C000_0015);
        sweep_ev(2'd1, 33'h1_4000_0015, 33'h0);
        wr(REG_CMD, 32'h10);
        wr(REG_SWCFG, 32'h0);
        wr(REG_UNITMAP, 32'h4);
    endtask
    task automatic done_pulse;
        @(posedge clk_sys);
        sweep_done <= 1'b1;
        @(posedge clk_sys);
        sweep_done <= 1'b0;
    endtask
    // One event on input one; checks whether it was taken
    task automatic ev_one(input logic e);
        @(posedge clk_sys);
        ev_in <= '{1'b1, 2'd0, 31'h15};
        @(posedge clk_sys);
        ev_in.valid <= 1'b0;
        #1 chk({32'h0, ev_out.valid}, {32'h0, e});
    endtask
    task automatic t_gate;
        wr(REG_CFG, 32'h700);
        wr(REG_SWCFG, 32'h4);
        wr(REG_PRESET, 32'h2);
        wr(REG_CMD, 32'h1);
        tick(4);
        chk({31'h0, gate_oe, gate_o}, 33'h3);
        ev_one(1'b1);
        done_pulse;
        tick(2);
        chk({31'h0, gate_oe, gate_o}, 33'h3);
        done_pulse;
        tick(2);
        chk({31'h0, gate_oe, gate_o}, 33'h2);
        rd(REG_STATUS, 32'h0);
        wr(REG_CFG, 32'h500);
        wr(REG_CMD, 32'h1);
        tick(4);
        ev_one(1'b0);
        wr(REG_CMD, 32'h10);
        tick(2);
        chk({32'h0, gate_oe}, 33'h0);
    endtask

    // Reset, then the scenarios in turn
    initial begin
        repeat (16) @(posedge clk_sys);
        resetn <= 1'b1;
        tick(2);
        t_regs;
        t_status;
        t_value;
        t_trig;
        t_events;
        t_gate;
        stop_test;
    end
endmodule
